// ==== core/ext_ctx_regs.svh ====
`ifndef EXT_CTX_REGS_SVH
`define EXT_CTX_REGS_SVH

// field positions inside the 128-bit extended context entry
`define EXEC_REQ_EN_BIT 90
`define CACHE_DIS_BIT 70
`define WR_PROT_EN_BIT 69
`define NO_EXEC_EN_BIT 68
`define GLOBAL_EN_BIT 67
`define GUEST_WIDTH_MSB 66
`define GUEST_WIDTH_LSB 64
`define TABLE_BASE_MSB 63
`define TABLE_BASE_LSB 12
`define PASID_EN_BIT 11

// field positions inside a first-level paging entry
`define EXEC_DIS_FLAG_BIT 63
`define PTE_GLOBAL_BIT 8

// guest width codes
`define GW30_CODE 3'h0
`define GW39_CODE 3'h1
`define GW48_CODE 3'h2
`define GW57_CODE 3'h3
`define GW64_CODE 3'h4

// width in address bits per code
`define GW30_BITS 7'h1e
`define GW39_BITS 7'h27
`define GW48_BITS 7'h30
`define GW57_BITS 7'h39
`define GW64_BITS 7'h40

// table levels per code
`define GW30_LEVELS 3'h2
`define GW39_LEVELS 3'h3
`define GW48_LEVELS 3'h4
`define GW57_LEVELS 3'h5
`define GW64_LEVELS 3'h6

// reset values
`define RSP_RST 1'h0
`define SNOOP_RST 1'h0

`endif

// ==== core/ext_ctx_pkg.sv ====
package ext_ctx_pkg;

    typedef enum logic [2:0] {
        FAULT_NONE,
        FAULT_PASID_OFF,
        FAULT_BAD_WIDTH,
        FAULT_RANGE,
        FAULT_WRITE_PROT,
        FAULT_NO_EXEC
    } fault_t;

    typedef struct packed {
        logic valid;
        logic has_pasid;
        logic untranslated;
        logic is_write;
        logic is_exec;
        logic supervisor;
        logic coherent;
        logic line_hit;
        logic line_shared;
        logic pte_read_only;
        logic [63:0] pte;
        logic supervisor_req_enable;
        logic [63:0] addr;
    } req_t;

    typedef struct packed {
        logic valid;
        logic blocked;
        fault_t fault;
        logic uncacheable;
        logic cache_lookup;
        logic line_fill;
        logic mem_update;
        logic global_page;
    } rsp_t;

    typedef struct packed {
        logic width_ok;
        logic [2:0] walk_levels;
        logic [6:0] guest_width;
        logic [63:0] table_base;
    } walk_cfg_t;

endpackage

// ==== core/guest_width_decode.sv ====
`timescale 1ns/10ps
`include "ext_ctx_regs.svh"

module guest_width_decode (
    input wire logic [2:0] code,
    input wire logic [4:0] supported,
    input wire logic [63:0] addr,
    output logic [2:0] levels,
    output logic [6:0] width,
    output logic legal,
    output logic beyond
);
    always_comb begin
        levels = 3'h0;
        width = 7'h00;
        legal = 1'b0;
        case (code)
            `GW30_CODE: begin
                levels = `GW30_LEVELS;
                width = `GW30_BITS;
                legal = supported[0];
            end
            `GW39_CODE: begin
                levels = `GW39_LEVELS;
                width = `GW39_BITS;
                legal = supported[1];
            end
            `GW48_CODE: begin
                levels = `GW48_LEVELS;
                width = `GW48_BITS;
                legal = supported[2];
            end
            `GW57_CODE: begin
                levels = `GW57_LEVELS;
                width = `GW57_BITS;
                legal = supported[3];
            end
            `GW64_CODE: begin
                levels = `GW64_LEVELS;
                width = `GW64_BITS;
                legal = supported[4];
            end
            default: begin
                legal = 1'b0;
            end
        endcase
    end

    // a 64-bit window covers every address, so nothing can lie above it
    always_comb begin
        if (!legal || width == `GW64_BITS) begin
            beyond = 1'b0;
        end else begin
            beyond = |(addr >> width);
        end
    end
endmodule

// ==== core/ext_context_entry_decode.sv ====
`timescale 1ns/10ps
`include "ext_ctx_regs.svh"

module ext_context_entry_decode
    import ext_ctx_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [127:0] ext_entry,
    input wire logic memtype_supported,
    input wire logic [4:0] supported_guest_widths,
    input wire logic [6:0] host_addr_width,
    input wire req_t req,
    output rsp_t rsp_q,
    output walk_cfg_t walk_cfg_q,
    output logic snoop_enable_q
);
    logic cache_disable;
    logic write_protect_enable;
    logic no_exec_enable;
    logic global_page_enable;
    logic process_space_id_enable;
    logic execute_req_enable;
    logic [2:0] address_width;
    logic force_uncacheable;
    logic exec_disable_flag;
    logic pte_global;
    logic [2:0] levels;
    logic [6:0] guest_width;
    logic width_legal;
    logic addr_beyond;
    fault_t fault_d;
    rsp_t rsp_d;
    walk_cfg_t walk_cfg_d;

    // field extraction with the ignore conditions applied
    always_comb begin
        process_space_id_enable = ext_entry[`PASID_EN_BIT];
        execute_req_enable = ext_entry[`EXEC_REQ_EN_BIT];
        address_width = ext_entry[`GUEST_WIDTH_MSB:`GUEST_WIDTH_LSB];
        cache_disable = ext_entry[`CACHE_DIS_BIT] & memtype_supported;
        write_protect_enable = ext_entry[`WR_PROT_EN_BIT] & process_space_id_enable
                               & req.supervisor_req_enable;
        no_exec_enable = ext_entry[`NO_EXEC_EN_BIT] & process_space_id_enable
                         & execute_req_enable;
        global_page_enable = ext_entry[`GLOBAL_EN_BIT] & process_space_id_enable;
        exec_disable_flag = req.pte[`EXEC_DIS_FLAG_BIT];
        pte_global = req.pte[`PTE_GLOBAL_BIT];
    end

    // cache disable applies to coherent requests only; non-coherent ones keep the normal cache lookup
    assign force_uncacheable = cache_disable & req.coherent;

    guest_width_decode u_width (
        .code(address_width),
        .supported(supported_guest_widths),
        .addr(req.addr),
        .levels(levels),
        .width(guest_width),
        .legal(width_legal),
        .beyond(addr_beyond)
    );

    // fault priority: a broken entry outranks any per-request check
    always_comb begin
        if (!width_legal) begin
            fault_d = FAULT_BAD_WIDTH;
        end else if (req.has_pasid && !process_space_id_enable) begin
            fault_d = FAULT_PASID_OFF;
        end else if (req.untranslated && !req.has_pasid && addr_beyond) begin
            fault_d = FAULT_RANGE;
        end else if (req.is_write && req.supervisor && req.pte_read_only && write_protect_enable) begin
            fault_d = FAULT_WRITE_PROT;
        end else if (req.is_exec && exec_disable_flag && no_exec_enable) begin
            fault_d = FAULT_NO_EXEC;
        end else begin
            fault_d = FAULT_NONE;
        end
    end

    // cache policy for one request
    always_comb begin
        rsp_d = '0;
        rsp_d.valid = req.valid;
        rsp_d.fault = req.valid ? fault_d : FAULT_NONE;
        rsp_d.blocked = req.valid && fault_d != FAULT_NONE;
        rsp_d.uncacheable = req.valid && force_uncacheable;
        rsp_d.global_page = req.valid && global_page_enable && pte_global;
        if (req.valid && !rsp_d.blocked) begin
            if (force_uncacheable) begin
                // every access goes straight to memory, nothing is allocated
                rsp_d.mem_update = req.is_write;
            end else begin
                rsp_d.cache_lookup = 1'b1;
                if (req.is_write) begin
                    rsp_d.line_fill = !req.line_hit;
                    rsp_d.mem_update = !req.line_hit || req.line_shared;
                end else begin
                    // a read miss may evict a victim line
                    rsp_d.line_fill = !req.line_hit;
                end
            end
        end
    end

    // walk setup follows the entry continuously
    always_comb begin
        walk_cfg_d.width_ok = width_legal;
        walk_cfg_d.walk_levels = levels;
        walk_cfg_d.guest_width = guest_width;
        walk_cfg_d.table_base = '0;
        for (int i = `TABLE_BASE_LSB; i <= `TABLE_BASE_MSB; i++) begin
            walk_cfg_d.table_base[i] = ext_entry[i] & (7'(i) < host_addr_width);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_q <= '0;
        end else begin
            rsp_q <= rsp_d;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            walk_cfg_q <= '0;
        end else begin
            walk_cfg_q <= walk_cfg_d;
        end
    end

    // snooping is independent of cache disable; it only waits for reset release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            snoop_enable_q <= `SNOOP_RST;
        end else begin
            snoop_enable_q <= 1'b1;
        end
    end

    a_cache_dis_reserved: assert property (
        @(posedge clk) disable iff (!rst_n)
        req.valid && !memtype_supported |=> !rsp_q.uncacheable)
        else $error("cache disable honoured without memory-type support");

    a_noncoh_cached: assert property (
        @(posedge clk) disable iff (!rst_n)
        req.valid && !req.coherent |=> !rsp_q.uncacheable)
        else $error("non-coherent request forced uncacheable");

    a_cache_dis_forces: assert property (
        @(posedge clk) disable iff (!rst_n)
        req.valid && req.coherent && memtype_supported && ext_entry[`CACHE_DIS_BIT]
        |=> rsp_q.uncacheable && !rsp_q.cache_lookup && !rsp_q.line_fill)
        else $error("cache disable did not force uncacheable");

    a_snoop_kept: assert property (
        @(posedge clk) disable iff (!rst_n)
        ext_entry[`CACHE_DIS_BIT] ##1 ext_entry[`CACHE_DIS_BIT] |-> snoop_enable_q)
        else $error("snoop answer dropped under cache disable");

    a_write_miss: assert property (
        @(posedge clk) disable iff (!rst_n)
        rsp_q.valid && !rsp_q.blocked && !rsp_q.uncacheable
        && $past(req.is_write) && !$past(req.line_hit)
        |-> rsp_q.line_fill && rsp_q.mem_update && rsp_q.cache_lookup)
        else $error("write miss without line fill and memory update");

    a_wp_ignored: assert property (
        @(posedge clk) disable iff (!rst_n)
        req.valid && (!ext_entry[`PASID_EN_BIT] || !req.supervisor_req_enable)
        |=> rsp_q.fault != FAULT_WRITE_PROT)
        else $error("write protect applied while ignored");

    a_wp_blocks: assert property (
        @(posedge clk) disable iff (!rst_n)
        req.valid && width_legal && !addr_beyond && ext_entry[`PASID_EN_BIT]
        && req.supervisor_req_enable && ext_entry[`WR_PROT_EN_BIT]
        && req.is_write && req.supervisor && req.pte_read_only
        |=> rsp_q.blocked && rsp_q.fault == FAULT_WRITE_PROT)
        else $error("supervisor write to read-only page passed");

    a_nx_ignored: assert property (
        @(posedge clk) disable iff (!rst_n)
        req.valid && (!ext_entry[`PASID_EN_BIT] || !ext_entry[`EXEC_REQ_EN_BIT])
        |=> rsp_q.fault != FAULT_NO_EXEC)
        else $error("no-execute applied while ignored");

    a_nx_blocks: assert property (
        @(posedge clk) disable iff (!rst_n)
        req.valid && width_legal && ext_entry[`PASID_EN_BIT]
        && !(req.untranslated && !req.has_pasid && addr_beyond)
        && !(req.is_write && req.supervisor && req.pte_read_only && req.supervisor_req_enable
        && ext_entry[`WR_PROT_EN_BIT])
        && ext_entry[`EXEC_REQ_EN_BIT] && ext_entry[`NO_EXEC_EN_BIT]
        && req.is_exec && req.pte[`EXEC_DIS_FLAG_BIT]
        |=> rsp_q.fault == FAULT_NO_EXEC)
        else $error("fetch from execute-disabled page passed");

    a_global_page: assert property (
        @(posedge clk) disable iff (!rst_n)
        req.valid |=> rsp_q.global_page == ($past(ext_entry[`GLOBAL_EN_BIT])
        && $past(ext_entry[`PASID_EN_BIT]) && $past(req.pte[`PTE_GLOBAL_BIT])))
        else $error("global page marking wrong");

    a_walk_depth: assert property (
        @(posedge clk) disable iff (!rst_n)
        ext_entry[`GUEST_WIDTH_MSB:`GUEST_WIDTH_LSB] == `GW48_CODE
        |=> walk_cfg_q.walk_levels == `GW48_LEVELS && walk_cfg_q.guest_width == `GW48_BITS)
        else $error("48-bit code did not give four levels");

    a_range_fault: assert property (
        @(posedge clk) disable iff (!rst_n)
        req.valid && width_legal && req.untranslated && !req.has_pasid
        && address_width == `GW39_CODE && |req.addr[63:39]
        |=> rsp_q.blocked && rsp_q.fault == FAULT_RANGE)
        else $error("address above window not faulted");

    a_base_reserved: assert property (
        @(posedge clk) disable iff (!rst_n)
        host_addr_width == 7'h27 |=> walk_cfg_q.table_base[63:39] == 25'h0)
        else $error("table base bits above host width not cleared");

    a_pasid_block: assert property (
        @(posedge clk) disable iff (!rst_n)
        req.valid && width_legal && req.has_pasid && !ext_entry[`PASID_EN_BIT]
        |=> rsp_q.blocked && rsp_q.fault == FAULT_PASID_OFF && !rsp_q.mem_update)
        else $error("request with id passed while ids disabled");

    a_bad_width: assert property (
        @(posedge clk) disable iff (!rst_n)
        req.valid && ext_entry[`GUEST_WIDTH_MSB:`GUEST_WIDTH_LSB] > `GW64_CODE
        |=> rsp_q.blocked && rsp_q.fault == FAULT_BAD_WIDTH && !walk_cfg_q.width_ok)
        else $error("reserved width code not faulted");

    a_uncached_write: assert property (
        @(posedge clk) disable iff (!rst_n)
        req.valid && req.coherent && memtype_supported && ext_entry[`CACHE_DIS_BIT]
        |=> rsp_q.blocked || rsp_q.mem_update == $past(req.is_write))
        else $error("uncached access did not go straight to memory");

    a_snoop_always: assert property (
        @(posedge clk) disable iff (!rst_n)
        1'b1 |=> snoop_enable_q)
        else $error("snoop answer off after reset");

    a_read_hit: assert property (
        @(posedge clk) disable iff (!rst_n)
        req.valid && !req.is_write && req.line_hit
        && !(req.coherent && memtype_supported && ext_entry[`CACHE_DIS_BIT])
        |=> rsp_q.blocked || (rsp_q.cache_lookup && !rsp_q.line_fill && !rsp_q.mem_update))
        else $error("read hit did not stay in the cache");

    a_shared_write: assert property (
        @(posedge clk) disable iff (!rst_n)
        req.valid && req.is_write && req.line_hit && req.line_shared
        && !(req.coherent && memtype_supported && ext_entry[`CACHE_DIS_BIT])
        |=> rsp_q.blocked || (rsp_q.cache_lookup && !rsp_q.line_fill && rsp_q.mem_update))
        else $error("write to shared line did not update memory");

    a_user_write_free: assert property (
        @(posedge clk) disable iff (!rst_n)
        req.valid && !req.supervisor |=> rsp_q.fault != FAULT_WRITE_PROT)
        else $error("user-level write faulted by write protect");

    a_nx_off_allows: assert property (
        @(posedge clk) disable iff (!rst_n)
        req.valid && !ext_entry[`NO_EXEC_EN_BIT] |=> rsp_q.fault != FAULT_NO_EXEC)
        else $error("fetch refused with no-execute clear");

    a_walk_widest: assert property (
        @(posedge clk) disable iff (!rst_n)
        ext_entry[`GUEST_WIDTH_MSB:`GUEST_WIDTH_LSB] == `GW64_CODE
        |=> walk_cfg_q.walk_levels == `GW64_LEVELS && walk_cfg_q.guest_width == `GW64_BITS)
        else $error("64-bit code did not give six levels");

    a_wide_no_range: assert property (
        @(posedge clk) disable iff (!rst_n)
        req.valid && ext_entry[`GUEST_WIDTH_MSB:`GUEST_WIDTH_LSB] == `GW64_CODE
        |=> rsp_q.fault != FAULT_RANGE)
        else $error("range fault under a 64-bit window");

    a_base_low_zero: assert property (
        @(posedge clk) disable iff (!rst_n)
        1'b1 |=> walk_cfg_q.table_base[11:0] == 12'h000)
        else $error("table base has bits below the page offset");

    a_blocked_quiet: assert property (
        @(posedge clk) disable iff (!rst_n)
        req.valid |=> !rsp_q.blocked || !(rsp_q.cache_lookup || rsp_q.line_fill || rsp_q.mem_update))
        else $error("blocked request still touched cache or memory");

endmodule

// ==== verif/dma_requester.sv ====
`timescale 1ns/10ps

module dma_requester
    import ext_ctx_pkg::*;
(
    output req_t req
);
    initial begin
        req = '0;
    end

    // the bench calls this just after a falling edge, so the request is settled at the taking edge
    task automatic issue(input req_t r);
        req = r;
    endtask

    function automatic req_t random_req();
        logic [159:0] raw;
        req_t r;
        raw = {$urandom, $urandom, $urandom, $urandom, $urandom};
        r = raw[$bits(req_t)-1:0];
        r.valid = 1'b1;
        // a device without an id issues only plain user data traffic
        if (!r.has_pasid) begin
            r.supervisor = 1'b0;
            r.is_exec = 1'b0;
            r.pte[8] = 1'b0;
        end
        // spread addresses so both sides of every width window are hit
        r.addr = r.addr >> ($urandom % 64);
        return r;
    endfunction
endmodule

// ==== verif/testbench.sv ====
`timescale 1ns/10ps

module testbench;
    import ext_ctx_pkg::*;
    logic clk;
    logic rst_n;
    logic [127:0] ext_entry;
    logic memtype_supported;
    logic [4:0] supported_guest_widths;
    logic [6:0] host_addr_width;
    req_t req;
    rsp_t rsp_q;
    walk_cfg_t walk_cfg_q;
    logic snoop_enable_q;
    int err_count;
    int num_checks;
    req_t p_req;
    logic [127:0] p_e;
    logic p_ms;
    logic [4:0] p_sg;
    logic [6:0] p_hw;

    dma_requester dma_requester_inst (.req(req));

    ext_context_entry_decode ext_context_entry_decode_inst (
        .clk(clk),
        .rst_n(rst_n),
        .ext_entry(ext_entry),
        .memtype_supported(memtype_supported),
        .supported_guest_widths(supported_guest_widths),
        .host_addr_width(host_addr_width),
        .req(req),
        .rsp_q(rsp_q),
        .walk_cfg_q(walk_cfg_q),
        .snoop_enable_q(snoop_enable_q)
    );

    function automatic walk_cfg_t exp_walk(input logic [127:0] e, input logic [4:0] sg, input logic [6:0] hw);
        walk_cfg_t w;
        logic [2:0] c;
        c = e[66:64];
        w = '0;
        w.width_ok = (c <= 3'h4) ? sg[c] : 1'b0;
        // a defined code reports its depth and width even when the hardware lacks it
        if (c <= 3'h4) begin
            w.walk_levels = c + 3'h2;
            w.guest_width = (c == 3'h4) ? 7'h40 : 7'h1e + 7'h09 * {4'h0, c};
        end
        for (int i = 12; i < 64; i++) begin
            w.table_base[i] = (i < hw) ? e[i] : 1'b0;
        end
        return w;
    endfunction

    function automatic rsp_t exp_rsp(input logic [127:0] e, input logic ms, input logic [4:0] sg, input req_t r);
        rsp_t s;
        walk_cfg_t w;
        logic pe;
        s = '0;
        if (!r.valid) begin
            return s;
        end
        w = exp_walk(e, sg, 7'h40);
        pe = e[11];
        s.valid = 1'b1;
        s.uncacheable = e[70] & ms & r.coherent;
        s.global_page = pe & e[67] & r.pte[8];
        if (!w.width_ok) begin
            s.fault = FAULT_BAD_WIDTH;
        end else if (r.has_pasid && !pe) begin
            s.fault = FAULT_PASID_OFF;
        end else if (r.untranslated && !r.has_pasid && w.guest_width != 7'h40 && (r.addr >> w.guest_width) != 64'h0) begin
            s.fault = FAULT_RANGE;
        end else if (pe && e[69] && r.supervisor_req_enable && r.supervisor && r.is_write && r.pte_read_only) begin
            s.fault = FAULT_WRITE_PROT;
        end else if (pe && e[90] && e[68] && r.is_exec && r.pte[63]) begin
            s.fault = FAULT_NO_EXEC;
        end
        s.blocked = (s.fault != FAULT_NONE);
        if (!s.blocked) begin
            s.cache_lookup = !s.uncacheable;
            s.line_fill = !s.uncacheable && !r.line_hit;
            s.mem_update = r.is_write && (s.uncacheable || !r.line_hit || r.line_shared);
        end
        return s;
    endfunction

    task automatic fail(input string msg);
        err_count++;
        $display("CHECK FAILED at %0t: %s", $time, msg);
    endtask

    task automatic summarize();
        $display("checks %0d, errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // compares the answer to the request taken on the last rising edge, then presents the next one
    task automatic step(input logic [127:0] e, input logic ms, input logic [4:0] sg, input logic [6:0] hw,
                        input req_t r);
        @(negedge clk);
        num_checks += 3;
        if (rsp_q !== exp_rsp(p_e, p_ms, p_sg, p_req)) fail("response mismatch");
        if (walk_cfg_q !== exp_walk(p_e, p_sg, p_hw)) fail("walk config mismatch");
        if (snoop_enable_q !== 1'b1) fail("snoop answer off");
        ext_entry = e;
        memtype_supported = ms;
        supported_guest_widths = sg;
        host_addr_width = hw;
        dma_requester_inst.issue(r);
        p_e = e;
        p_ms = ms;
        p_sg = sg;
        p_hw = hw;
        p_req = r;
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        #40000;
        fail("watchdog expired");
        summarize();
    end

    initial begin
        req_t r;
        logic [127:0] e;
        logic [63:0] lim;
        err_count = 0;
        num_checks = 0;
        void'($urandom(78));
        rst_n = 1'b0;
        ext_entry = '0;
        memtype_supported = 1'b0;
        supported_guest_widths = 5'h1f;
        host_addr_width = 7'h40;
        p_req = '0;
        p_e = '0;
        p_ms = 1'b0;
        p_sg = 5'h1f;
        p_hw = 7'h40;
        repeat (6) @(negedge clk);
        num_checks++;
        if (snoop_enable_q !== 1'b0 || rsp_q !== '0) fail("outputs not cleared in reset");
        rst_n = 1'b1;
        // every width code, supported and not; last legal and first illegal address for codes 0 to 3, all ones and zero for the rest
        for (int c = 0; c < 8; c++) begin
            for (int s = 0; s < 2; s++) begin
                for (int k = 0; k < 2; k++) begin
                    e = '0;
                    e[11] = 1'b1;
                    e[66:64] = 3'(c);
                    r = '0;
                    r.valid = 1'b1;
                    r.untranslated = 1'b1;
                    lim = (c < 4) ? (64'h1 << (30 + 9 * c)) : 64'h0;
                    r.addr = lim - 64'h1 + 64'(k);
                    step(e, 1'b0, (s != 0) ? 5'h1f ^ 5'(1 << c) : 5'h1f, 7'h40, r);
                end
            end
        end
        e = '0;
        e[66:64] = 3'h2;
        step(e, 1'b0, 5'h07, 7'h40, r);
        for (int i = 0; i < 64; i++) begin
            e = '0;
            e[70] = i[0];
            e[66:64] = 3'h1;
            r = '0;
            r.valid = 1'b1;
            r.coherent = i[2];
            r.is_write = i[3];
            r.line_hit = i[4];
            r.line_shared = i[5];
            step(e, i[1], 5'h1f, 7'h40, r);
        end
        for (int i = 0; i < 512; i++) begin
            e = '0;
            e[11] = i[0];
            e[69] = i[1];
            e[90] = i[4];
            e[68] = i[5];
            e[67] = i[7];
            e[66:64] = 3'h2;
            r = '0;
            r.valid = 1'b1;
            r.has_pasid = 1'b1;
            r.supervisor = 1'b1;
            r.supervisor_req_enable = i[2];
            r.pte_read_only = i[3];
            r.pte[63] = i[6];
            r.pte[8] = i[2];
            r.is_exec = i[8];
            r.is_write = !i[8];
            step(e, 1'b0, 5'h1f, 7'h40, r);
        end
        for (int k = 0; k < 9; k++) begin
            e = {$urandom, $urandom, $urandom, $urandom};
            r = '0;
            step(e, 1'b0, 5'h1f, 7'h20 + 7'(4 * k), r);
        end
        for (int n = 0; n < 400; n++) begin
            e = {$urandom, $urandom, $urandom, $urandom};
            r = dma_requester_inst.random_req();
            r.valid = (($urandom % 4) != 0);
            step(e, 1'($urandom), 5'($urandom), 7'h20 + 7'($urandom % 33), r);
        end
        r = '0;
        step('0, 1'b0, 5'h1f, 7'h40, r);
        step('0, 1'b0, 5'h1f, 7'h40, r);
        summarize();
    end
endmodule
